// File: rpc_pkg.sv
// Purpose: constants and types for the radio packet configuration bank
// Assumes: byte-wide registers on a 32-bit classic wishbone word map
// Notes: byte address is four times the register index
package rpc_pkg;
  // ==========================================================
  // register indexes and bus address width
  localparam logic [7:0] RPC_IDX_CLKREC = 8'h23;
  localparam logic [7:0] RPC_IDX_AGC_TIME = 8'h24;
  localparam logic [7:0] RPC_IDX_AGC_THR = 8'h25;
  localparam logic [7:0] RPC_IDX_AGC_EN = 8'h26;
  localparam logic [7:0] RPC_IDX_ANT = 8'h27;
  localparam logic [7:0] RPC_IDX_PKT_LEN = 8'h30;
  localparam logic [7:0] RPC_IDX_PKT_FMT = 8'h31;
  localparam logic [7:0] RPC_IDX_PKT_LCFG = 8'h32;
  localparam logic [7:0] RPC_IDX_PKT_CODE = 8'h33;
  localparam logic [7:0] RPC_IDX_LOOP_SEL = 8'h1c;
  localparam int RPC_ADDR_W = 10;
  // ==========================================================
  // reset values
  localparam logic [7:0] RPC_RST_CLKREC = 8'h58;
  localparam logic [7:0] RPC_RST_AGC_TIME = 8'h22;
  localparam logic [7:0] RPC_RST_AGC_THR = 8'h65;
  localparam logic [7:0] RPC_RST_AGC_EN = 8'h8a;
  localparam logic [7:0] RPC_RST_ANT = 8'h05;
  localparam logic [7:0] RPC_RST_PKT_LEN = 8'h00;
  localparam logic [7:0] RPC_RST_PKT_FMT = 8'h07;
  localparam logic [7:0] RPC_RST_PKT_LCFG = 8'h1e;
  localparam logic [7:0] RPC_RST_PKT_CODE = 8'h20;
  localparam logic [7:0] RPC_RST_LOOP_SEL = 8'h00;
  // ==========================================================
  // writable masks, reserved bits keep reset contents
  localparam logic [7:0] RPC_WM_AGC_TIME = 8'h0f;
  localparam logic [7:0] RPC_WM_AGC_EN = 8'h80;
  localparam logic [7:0] RPC_WM_ANT = 8'h1f;
  localparam logic [7:0] RPC_WM_PKT_LEN = 8'h1f;
  localparam logic [7:0] RPC_WM_PKT_CODE = 8'he0;
  localparam logic [7:0] RPC_WM_LOOP_SEL = 8'h08;
  // ==========================================================
  // post-filter spans in symbols
  localparam logic [4:0] RPC_PSTFLT_SHORT = 5'h08;
  localparam logic [4:0] RPC_PSTFLT_LONG = 5'h10;
  // crc polynomials
  localparam logic [23:0] RPC_POLY_8 = 24'h000007;
  localparam logic [23:0] RPC_POLY_16A = 24'h008005;
  localparam logic [23:0] RPC_POLY_16B = 24'h001021;
  localparam logic [23:0] RPC_POLY_24 = 24'h864cbf;

  typedef enum logic [1:0] {
    RPC_FMT_BASIC = 2'h0,
    RPC_FMT_RSVD = 2'h1,
    RPC_FMT_MBUS = 2'h2,
    RPC_FMT_EXT = 2'h3
  } rpc_fmt_t;

  typedef enum logic [1:0] {
    RPC_RX_NORMAL = 2'h0,
    RPC_RX_FIFO = 2'h1,
    RPC_RX_PIN = 2'h2,
    RPC_RX_RSVD = 2'h3
  } rpc_rx_mode_t;

  typedef struct packed {
    logic [2:0] prop_gain;
    logic [4:0] postfilter_symbols;
    logic [3:0] integral_gain;
    logic integral_active;
    logic loop_is_pll;
    logic [3:0] thr_high;
    logic [3:0] thr_low;
    logic [3:0] agc_measure_time;
    logic gain_control_on;
    logic antenna_switch_on;
    logic [2:0] antenna_measure_time;
  } rpc_rx_cfg_t;

  typedef struct packed {
    rpc_fmt_t format;
    rpc_rx_mode_t rx_mode;
    logic [1:0] address_field_bytes;
    logic addressed_format;
    logic [2:0] control_field_bytes;
    logic [3:0] length_field_width;
    logic [5:0] preamble_bytes;
    logic [2:0] sync_bytes;
    logic variable_length_select;
    logic [2:0] crc_mode;
    logic crc_on;
    logic [23:0] crc_poly;
  } rpc_pkt_cfg_t;
endpackage : rpc_pkg

// File: rpc_regs.sv
// Purpose: configuration register bank for receiver and packet engine
// Assumes: classic wishbone slave, one clock, synchronous reset
// Notes: ack comes one cycle after the request is seen
//
// Summary of operation
// - proportional loop gain held in bits 7:5
// - post-filter eight or sixteen symbols
// - integral gain 3:0, used only in pll
// - gain control high and low thresholds
// - blanking stops fifo writes below carrier sense
// - antenna switching enabled by bit 3
// - address field bytes from bits 4:3
// - control field bytes from bits 2:0
// - packet format select from bits 7:6
// - receive mode select from bits 5:4
// - length field width from bits 3:0
// - preamble bytes one to thirty-two
// - sync word one to four bytes
// - bit 0 selects fixed or variable length
// - crc select none or four polynomials
// - pll or dll chosen by mode bit
//
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module rpc_regs
  import rpc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [RPC_ADDR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic rx_data_valid_i,
  input wire logic carrier_sense_i,
  output logic rx_fifo_write_o,
  output var rpc_rx_cfg_t rx_cfg_o,
  output var rpc_pkt_cfg_t pkt_cfg_o
);
  // ==========================================================
  // bus decode
  logic ack_ff;
  logic [31:0] rdat_ff;
  logic [7:0] reg_idx;
  logic req;
  logic wr;
  logic [7:0] wbyte;
  assign reg_idx = wb_adr_i[RPC_ADDR_W-1:2];
  assign req = wb_cyc_i & wb_stb_i & ~ack_ff;
  assign wr = req & wb_we_i & wb_sel_i[0];
  assign wbyte = wb_dat_i[7:0];

  logic [7:0] clkrec_ff, agc_time_ff, agc_thr_ff, agc_en_ff, ant_ff;
  logic [7:0] pkt_len_ff, pkt_fmt_ff, pkt_lcfg_ff, pkt_code_ff, loop_sel_ff;

  // merge writable bits, reserved bits keep their contents
  function automatic logic [7:0] rpc_merge(input logic [7:0] old_v, input logic [7:0] new_v,
                                           input logic [7:0] wmask);
    rpc_merge = (old_v & ~wmask) | (new_v & wmask);
  endfunction : rpc_merge

  // ==========================================================
  // register writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clkrec_ff <= RPC_RST_CLKREC;
      agc_time_ff <= RPC_RST_AGC_TIME;
      agc_thr_ff <= RPC_RST_AGC_THR;
      agc_en_ff <= RPC_RST_AGC_EN;
      ant_ff <= RPC_RST_ANT;
      pkt_len_ff <= RPC_RST_PKT_LEN;
      pkt_fmt_ff <= RPC_RST_PKT_FMT;
      pkt_lcfg_ff <= RPC_RST_PKT_LCFG;
      pkt_code_ff <= RPC_RST_PKT_CODE;
      loop_sel_ff <= RPC_RST_LOOP_SEL;
    end else if (wr) begin
      unique case (reg_idx)
        RPC_IDX_CLKREC: clkrec_ff <= wbyte;
        RPC_IDX_AGC_TIME: agc_time_ff <= rpc_merge(agc_time_ff, wbyte, RPC_WM_AGC_TIME);
        RPC_IDX_AGC_THR: agc_thr_ff <= wbyte;
        RPC_IDX_AGC_EN: agc_en_ff <= rpc_merge(agc_en_ff, wbyte, RPC_WM_AGC_EN);
        RPC_IDX_ANT: ant_ff <= rpc_merge(ant_ff, wbyte, RPC_WM_ANT);
        RPC_IDX_PKT_LEN: pkt_len_ff <= rpc_merge(pkt_len_ff, wbyte, RPC_WM_PKT_LEN);
        RPC_IDX_PKT_FMT: pkt_fmt_ff <= wbyte;
        RPC_IDX_PKT_LCFG: pkt_lcfg_ff <= wbyte;
        RPC_IDX_PKT_CODE: pkt_code_ff <= rpc_merge(pkt_code_ff, wbyte, RPC_WM_PKT_CODE);
        RPC_IDX_LOOP_SEL: loop_sel_ff <= rpc_merge(loop_sel_ff, wbyte, RPC_WM_LOOP_SEL);
        default: ;
      endcase
    end
  end

  // ==========================================================
  // read mux, unmapped reads zero
  logic [7:0] rd_byte;
  always_comb begin
    unique case (reg_idx)
      RPC_IDX_CLKREC: rd_byte = clkrec_ff;
      RPC_IDX_AGC_TIME: rd_byte = agc_time_ff;
      RPC_IDX_AGC_THR: rd_byte = agc_thr_ff;
      RPC_IDX_AGC_EN: rd_byte = agc_en_ff;
      RPC_IDX_ANT: rd_byte = ant_ff;
      RPC_IDX_PKT_LEN: rd_byte = pkt_len_ff;
      RPC_IDX_PKT_FMT: rd_byte = pkt_fmt_ff;
      RPC_IDX_PKT_LCFG: rd_byte = pkt_lcfg_ff;
      RPC_IDX_PKT_CODE: rd_byte = pkt_code_ff;
      RPC_IDX_LOOP_SEL: rd_byte = loop_sel_ff;
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      rdat_ff <= 32'h00000000;
    end else begin
      ack_ff <= req;
      rdat_ff <= {24'h000000, rd_byte};
    end
  end
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;

  // ==========================================================
  // decoded receiver settings
  wire loop_pll = ~loop_sel_ff[3];
  assign rx_cfg_o.prop_gain = clkrec_ff[7:5];
  assign rx_cfg_o.postfilter_symbols = clkrec_ff[4] ? RPC_PSTFLT_LONG : RPC_PSTFLT_SHORT;
  assign rx_cfg_o.integral_gain = loop_pll ? clkrec_ff[3:0] : 4'h0;
  assign rx_cfg_o.integral_active = loop_pll;
  assign rx_cfg_o.loop_is_pll = loop_pll;
  assign rx_cfg_o.thr_high = agc_thr_ff[7:4];
  assign rx_cfg_o.thr_low = agc_thr_ff[3:0];
  assign rx_cfg_o.agc_measure_time = agc_time_ff[3:0];
  assign rx_cfg_o.gain_control_on = agc_en_ff[7];
  assign rx_cfg_o.antenna_switch_on = ant_ff[3];
  assign rx_cfg_o.antenna_measure_time = ant_ff[3] ? ant_ff[2:0] : 3'h0;

  // blanking gate on fifo writes
  assign rx_fifo_write_o = rx_data_valid_i & ~(ant_ff[4] & ~carrier_sense_i);

  // ==========================================================
  // decoded packet settings
  assign pkt_cfg_o.format = rpc_fmt_t'(pkt_fmt_ff[7:6]);
  assign pkt_cfg_o.rx_mode = rpc_rx_mode_t'(pkt_fmt_ff[5:4]);
  assign pkt_cfg_o.length_field_width = pkt_fmt_ff[3:0];
  assign pkt_cfg_o.address_field_bytes = pkt_len_ff[4:3];
  assign pkt_cfg_o.addressed_format = (pkt_len_ff[4:3] == 2'h2);
  assign pkt_cfg_o.control_field_bytes = pkt_len_ff[2:0];
  assign pkt_cfg_o.preamble_bytes = {1'b0, pkt_lcfg_ff[7:3]} + 6'h01;
  assign pkt_cfg_o.sync_bytes = {1'b0, pkt_lcfg_ff[2:1]} + 3'h1;
  assign pkt_cfg_o.variable_length_select = pkt_lcfg_ff[0];
  assign pkt_cfg_o.crc_mode = pkt_code_ff[7:5];
  assign pkt_cfg_o.crc_on = (pkt_code_ff[7:5] != 3'h0) && (pkt_code_ff[7:5] <= 3'h4);
  logic [23:0] poly;
  always_comb begin
    unique case (pkt_code_ff[7:5])
      3'h1: poly = RPC_POLY_8;
      3'h2: poly = RPC_POLY_16A;
      3'h3: poly = RPC_POLY_16B;
      3'h4: poly = RPC_POLY_24;
      default: poly = 24'h000000;
    endcase
  end
  assign pkt_cfg_o.crc_poly = poly;
endmodule : rpc_regs
`default_nettype wire

// File: rpc_regs_sva.sv
// Purpose: bus timing and decode checks for rpc_regs
// Assumes: sees only the top module ports
// Notes: bound to the design after the module
`timescale 1ns/1ps
`default_nettype none
module rpc_regs_sva
  import rpc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [RPC_ADDR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic rx_data_valid_i,
  input wire logic carrier_sense_i,
  input wire logic rx_fifo_write_o,
  input wire rpc_rx_cfg_t rx_cfg_o,
  input wire rpc_pkt_cfg_t pkt_cfg_o
);
  // ==========================================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_no_write; !(wb_cyc_i && wb_stb_i && wb_we_i); endsequence
  // accepted byte write to one register index
  sequence s_write_to(logic [7:0] idx);
    wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && !wb_ack_o && (wb_adr_i[RPC_ADDR_W-1:2] == idx);
  endsequence
  a_ack_next_cycle: assert property (s_req |=> wb_ack_o) else $error("ack late");
  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  a_cfg_idle_hold: assert property (s_no_write |=> $stable(pkt_cfg_o) && $stable(rx_cfg_o))
    else $error("config moved without write");
  a_fifo_needs_valid: assert property (rx_fifo_write_o |-> rx_data_valid_i) else $error("fifo write");
  a_fifo_above_cs: assert property (rx_data_valid_i && carrier_sense_i |-> rx_fifo_write_o)
    else $error("fifo");
  a_postfilter_span: assert property (s_write_to(RPC_IDX_CLKREC) |=>
    rx_cfg_o.postfilter_symbols == (wb_dat_i[4] ? 5'h10 : 5'h08)) else $error("span");
  a_dll_no_integral: assert property (!rx_cfg_o.loop_is_pll |-> rx_cfg_o.integral_gain == 4'h0)
    else $error("integral gain in dll");
  a_antenna_off_time: assert property (
    !rx_cfg_o.antenna_switch_on |-> rx_cfg_o.antenna_measure_time == 3'h0) else $error("measure time while off");
  a_preamble_range: assert property (s_write_to(RPC_IDX_PKT_LCFG) |=>
    pkt_cfg_o.preamble_bytes == {1'b0, wb_dat_i[7:3]} + 6'h01) else $error("preamble length");
  a_sync_range: assert property (s_write_to(RPC_IDX_PKT_LCFG) |=>
    pkt_cfg_o.sync_bytes == {1'b0, wb_dat_i[2:1]} + 3'h1) else $error("sync length");
endmodule : rpc_regs_sva
bind rpc_regs rpc_regs_sva rpc_regs_sva_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .rx_data_valid_i(rx_data_valid_i), .carrier_sense_i(carrier_sense_i),
  .rx_fifo_write_o(rx_fifo_write_o), .rx_cfg_o(rx_cfg_o), .pkt_cfg_o(pkt_cfg_o));
`default_nettype wire

// File: tb_rpc_regs.sv
// Purpose: self-checking bench for rpc_regs
// Assumes: classic wishbone, ack one cycle after request
// Notes: random traffic from a fixed seed
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
  $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module tb_rpc_regs
  import rpc_pkg::*;
;
  logic clk_i, rst_i, cyc, stb, we, valid, cs, ack, fifo_w;
  logic [9:0] adr;
  logic [31:0] wdat, rdat;
  logic [3:0] sel;
  logic [7:0] q, cur [10];
  int bad_count, tests_run, i, m;
  rpc_rx_cfg_t rx;
  rpc_pkt_cfg_t pk;
  logic [7:0] adrs [10] = '{8'h8c, 8'h90, 8'h94, 8'h98, 8'h9c, 8'hc0, 8'hc4, 8'hc8, 8'hcc, 8'h70};
  logic [7:0] rstv [10] = '{8'h58, 8'h22, 8'h65, 8'h8a, 8'h05, 8'h00, 8'h07, 8'h1e, 8'h20, 8'h00};
  logic [7:0] msk [10] = '{8'hff, 8'h0f, 8'hff, 8'h80, 8'h1f, 8'h1f, 8'hff, 8'hff, 8'he0, 8'h08};
  rpc_regs rpc_regs_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack),
    .rx_data_valid_i(valid), .carrier_sense_i(cs), .rx_fifo_write_o(fifo_w), .rx_cfg_o(rx), .pkt_cfg_o(pk));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // ==========================================================
  // bus and expectation helpers
  task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] dd, input logic s);
    @(posedge clk_i);
    {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, 24'h0, dd, 3'h0, s};
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat[7:0];
    `CHK(rdat[31:8], 24'h000000)
    {cyc, stb} <= 2'b00;
  endtask : bus
  function automatic logic [23:0] poly(input logic [2:0] c);
    return c == 3'h1 ? RPC_POLY_8 : c == 3'h2 ? RPC_POLY_16A :
           c == 3'h3 ? RPC_POLY_16B : c == 3'h4 ? RPC_POLY_24 : 24'h0;
  endfunction : poly
  task automatic check_cfg;
    `CHK(rx.prop_gain, cur[0][7:5])
    `CHK(rx.postfilter_symbols, cur[0][4] ? 5'h10 : 5'h08)
    `CHK(rx.integral_gain, cur[9][3] ? 4'h0 : cur[0][3:0])
    `CHK({rx.thr_high, rx.thr_low}, cur[2])
    `CHK(rx.antenna_measure_time, cur[4][3] ? cur[4][2:0] : 3'h0)
    `CHK(pk.address_field_bytes, cur[5][4:3])
    `CHK(pk.control_field_bytes, cur[5][2:0])
    `CHK({pk.format, pk.rx_mode, pk.length_field_width}, cur[6])
    `CHK(pk.preamble_bytes, {1'b0, cur[7][7:3]} + 6'h01)
    `CHK(pk.sync_bytes, {1'b0, cur[7][2:1]} + 3'h1)
    `CHK(pk.variable_length_select, cur[7][0])
    `CHK(pk.crc_poly, poly(cur[8][7:5]))
    `CHK(rx.loop_is_pll, ~cur[9][3])
    `CHK(rx.gain_control_on, cur[3][7])
    `CHK(rx.integral_active, ~cur[9][3])
    `CHK(rx.agc_measure_time, cur[1][3:0])
    `CHK(rx.antenna_switch_on, cur[4][3])
    `CHK(pk.addressed_format, cur[5][4:3] == 2'h2)
    `CHK(pk.crc_mode, cur[8][7:5])
    `CHK(pk.crc_on, cur[8][7:5] inside {[3'h1:3'h4]})
  endtask : check_cfg
  task automatic check_reset;
    for (i = 0; i < 10; i++) begin
      cur[i] = rstv[i];
      bus(1'b0, {2'b00, adrs[i]}, 8'h00, 1'b1);
      `CHK(q, rstv[i])
    end
    check_cfg();
  endtask : check_reset
  task automatic wr(input int k, input logic [7:0] v);
    bus(1'b1, {2'b00, adrs[k]}, v, 1'b1);
    cur[k] = (cur[k] & ~msk[k]) | (v & msk[k]);
    bus(1'b0, {2'b00, adrs[k]}, 8'h00, 1'b1);
    `CHK(q, cur[k])
    check_cfg();
  endtask : wr
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : print_verdict
  initial begin
    #200000;
    bad_count++;
    print_verdict();
  end
  // ==========================================================
  // tests
  initial begin
    {rst_i, cyc, stb, we, valid, cs, adr, wdat, sel} = {1'b1, 5'h0, 10'h0, 32'h0, 4'h0};
    void'($urandom(32'h587b));
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    check_reset();
    $display("test reset values done");
    repeat (80) wr($urandom_range(9), 8'($urandom));
    $display("test random writes done");
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    check_reset();
    $display("test mid-run reset done");
    bus(1'b1, 10'h08c, ~cur[0], 1'b0);
    bus(1'b1, 10'h3fc, 8'hff, 1'b1);
    bus(1'b0, 10'h3fc, 8'h00, 1'b1);
    `CHK(q, 8'h00)
    bus(1'b0, 10'h08c, 8'h00, 1'b1);
    `CHK(q, cur[0])
    $display("test refused writes done");
    for (m = 0; m < 16; m++) wr(8, {m[2:0], 5'h0});
    for (m = 0; m < 2; m++) wr(9, {4'h0, m[0], 3'h0});
    for (m = 0; m < 2; m++) begin
      wr(4, m[0] ? 8'h1d : 8'h05);
      repeat (12) begin
        {valid, cs} <= 2'($urandom);
        @(posedge clk_i);
        @(posedge clk_i);
        `CHK(fifo_w, valid & (cs | ~cur[4][4]))
      end
    end
    $display("test crc, loop and blanking done");
    print_verdict();
  end
endmodule : tb_rpc_regs
`default_nettype wire
